// File: mtc_cfg.svh
`ifndef MTC_CFG_SVH
`define MTC_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MTC_OFS_CTRL      8'h00
`define MTC_OFS_SRC       8'h04
`define MTC_OFS_LEVEL     8'h08
`define MTC_OFS_HYST      8'h0C
`define MTC_OFS_DELAY     8'h10
`define MTC_OFS_AUTODLY   8'h14
`define MTC_OFS_HOLDOFF   8'h18
`define MTC_OFS_DROPOUT   8'h1C
`define MTC_OFS_COUNT     8'h20
`define MTC_OFS_CMD       8'h24
`define MTC_OFS_STATUS    8'h28
`define MTC_OFS_UNIT      8'h2C
`define MTC_OFS_ERROR     8'h30

// ----------------------------------------
// field positions
// ----------------------------------------
`define MTC_CTRL_CONT     0
`define MTC_CTRL_SLOPE    1
`define MTC_CTRL_AUTO     2
`define MTC_CTRL_MASTER   3
`define MTC_CTRL_HPCT     4
`define MTC_CMD_INIT      0
`define MTC_CMD_ABORT     1
`define MTC_CMD_FORCE     2
`define MTC_CMD_BUSTRG    3
`define MTC_CMD_ERRCLR    4
`define MTC_ERR_TRG       0
`define MTC_ERR_UNIT      1

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define MTC_RST_COUNT     16'h0001
`define MTC_ERR_TRG_CODE  16'hFF2D
`define MTC_ERR_UNIT_CODE 16'h001A
`define MTC_RESP_OKAY     2'h0
`define MTC_RESP_SLVERR   2'h2
`define MTC_MEAS_NS       1000
`define MTC_CLK_NS        50
`define MTC_MEAS_CYC      ((`MTC_MEAS_NS + `MTC_CLK_NS - 1) / `MTC_CLK_NS)

`endif

// File: mtc_pkg.sv
package mtc_pkg;
	typedef enum logic [2:0] {
		MTC_IDLE     = 3'b000,
		MTC_INIT     = 3'b001,
		MTC_WAIT     = 3'b010,
		MTC_DELAY    = 3'b011,
		MTC_MEASURE  = 3'b100
	} mtc_state_t;

	typedef enum logic [2:0] {
		MTC_SRC_BUS  = 3'b000,
		MTC_SRC_EXT  = 3'b001,
		MTC_SRC_HOLD = 3'b010,
		MTC_SRC_IMM  = 3'b011,
		MTC_SRC_INT  = 3'b100
	} mtc_src_t;

	typedef enum logic [1:0] {
		MTC_PWR_DBM  = 2'b00,
		MTC_PWR_W    = 2'b01,
		MTC_PWR_DBUV = 2'b10
	} mtc_pwr_unit_t;

	typedef enum logic [1:0] {
		MTC_RAT_DB   = 2'b00,
		MTC_RAT_DPCT = 2'b01,
		MTC_RAT_O    = 2'b10
	} mtc_rat_unit_t;
endpackage

// File: mtc_edge_if.sv
interface mtc_edge_if #(parameter int W = 16);
	logic [W-1:0] level;
	logic [W-1:0] hyst;
	logic         slope_neg;
	logic         armed;
	logic         edge_hit;
	modport det (input level, hyst, slope_neg, output armed, edge_hit);
	modport ctl (output level, hyst, slope_neg, input armed, edge_hit);
endinterface

// File: mtc_edge_det.sv
`include "mtc_cfg.svh"

module mtc_edge_det #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_arst_n,
	// measured power sample
	input  wire logic [W-1:0] i_power,
	// settings and result
	mtc_edge_if.det           e
);
	initial begin
		if (W < 2)
			$error("mtc_edge_det: bad W");
	end

	logic         above;
	logic [W:0]   lo_thr;
	logic [W:0]   hi_thr;
	logic         armed_q;

	// band below level for rising, above for falling
	assign lo_thr = {1'b0, e.level} - {1'b0, e.hyst};
	assign hi_thr = {1'b0, e.level} + {1'b0, e.hyst};
	assign above  = i_power > e.level;

	// --------------------------------
	// re-arm after leaving the band
	// --------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			armed_q <= 1'b0;
		end else if (e.edge_hit) begin
			armed_q <= 1'b0;
		end else if (!e.slope_neg) begin
			if (lo_thr[W] || {1'b0, i_power} < lo_thr)
				armed_q <= 1'b1;
		end else if ({1'b0, i_power} > hi_thr) begin
			armed_q <= 1'b1;
		end
	end

	// --------------------------------
	// crossing detection
	// --------------------------------
	always_comb begin
		e.edge_hit = armed_q && (e.slope_neg ? (i_power < e.level) : above);
	end
	assign e.armed = armed_q;
endmodule

// File: mtc_trigger.sv
// ----------------------------------------
// Overview of operation
// - after a trigger event wait the programmed delay before measuring.
// - auto delay waits a settle time; a longer programmed delay wins.
// - internal source: no retrigger until drop-out time after falling below.
// - ignore all source trigger events during hold-off after an accepted one; force still ends wait.
// - new edge needs signal past level by hysteresis, in dB or percent.
// - force trigger moves awaiting-trigger to measuring, any source.
// - forced trigger skips programmed delay but keeps auto settle delay.
// - force trigger outside awaiting-trigger is ignored and flags error -211.
// - internal trigger on rising above level (positive) or below (negative).
// - trigger master drives hardware trigger output on each accepted event.
// - rising edge for positive slope, falling edge for negative slope.
// - bus source triggers only from force or bus trigger command.
// - external source triggers on selected connector edge; force ends wait.
// - immediate source passes awaiting-trigger straight to measuring.
// - hold source measures only on force trigger command.
// - internal: measure after delay once level crossed; force ends wait.
// - power unit (dBm, W, dBuV; default dBm) governs power values.
// - ratio unit default dB; refused with error 26 for SWR-type compute.
// - cycle runs idle, initiated, awaiting, measuring; then idle or initiated.
// - abort returns to idle at once and stops measuring.
// - perform the configured count of measurement cycles per initiation.
// ----------------------------------------
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`include "mtc_cfg.svh"

module mtc_trigger #(
	parameter int W        = 16,
	parameter int TW       = 32,
	parameter int MEAS_CYC = `MTC_MEAS_CYC
) (
	// clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_arst_n,
	// measured signal and trigger line
	input  wire logic [W-1:0]  i_power,
	input  wire logic          i_ext_trig,
	input  wire logic          i_swr_compute,
	// trigger master output and status
	output logic               o_trig_out,
	output logic               o_measuring,
	output logic               o_meas_done,
	// axi4-lite write address
	input  wire logic [7:0]    i_awaddr,
	input  wire logic          i_awvalid,
	output logic               o_awready,
	// axi4-lite write data
	input  wire logic [31:0]   i_wdata,
	input  wire logic [3:0]    i_wstrb,
	input  wire logic          i_wvalid,
	output logic               o_wready,
	// axi4-lite write response
	output logic [1:0]         o_bresp,
	output logic               o_bvalid,
	input  wire logic          i_bready,
	// axi4-lite read address
	input  wire logic [7:0]    i_araddr,
	input  wire logic          i_arvalid,
	output logic               o_arready,
	// axi4-lite read data
	output logic [31:0]        o_rdata,
	output logic [1:0]         o_rresp,
	output logic               o_rvalid,
	input  wire logic          i_rready
);
	initial begin
		if (W < 2 || W > 32 || TW < 2 || TW > 32 || MEAS_CYC < 1)
			$error("mtc_trigger: bad parameter");
	end

	// --------------------------------
	// registers
	// --------------------------------
	logic [4:0]                   ctrl_q;
	mtc_pkg::mtc_src_t            src_q;
	logic [W-1:0]                 level_q;
	logic [W-1:0]                 hyst_q;
	logic [TW-1:0]                delay_q;
	logic [TW-1:0]                autodly_q;
	logic [TW-1:0]                holdoff_q;
	logic [TW-1:0]                dropout_q;
	logic [15:0]                  count_q;
	mtc_pkg::mtc_pwr_unit_t       pwr_unit_q;
	mtc_pkg::mtc_rat_unit_t       rat_unit_q;
	logic [1:0]                   err_q;
	mtc_pkg::mtc_state_t          state_q;
	logic [TW-1:0]                dly_cnt_q;
	logic [TW-1:0]                hold_cnt_q;
	logic [TW-1:0]                drop_cnt_q;
	logic [15:0]                  cyc_left_q;
	logic [15:0]                  meas_cnt_q;
	logic                         ext_q;
	logic                         was_above_q;

	// --------------------------------
	// axi4-lite slave
	// --------------------------------
	logic        aw_hold_q;
	logic        w_hold_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        wr_go;
	logic        wr_ok;
	logic        rd_ok;
	logic [31:0] rd_val;

	assign o_awready = !aw_hold_q && !o_bvalid;
	assign o_wready  = !w_hold_q && !o_bvalid;
	assign o_arready = !o_rvalid;
	assign wr_go     = aw_hold_q && w_hold_q && !o_bvalid;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			o_bvalid  <= 1'b0;
			o_bresp   <= `MTC_RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= i_wdata;
				wstrb_q  <= i_wstrb;
			end
			if (wr_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				o_bvalid  <= 1'b1;
				o_bresp   <= wr_ok ? `MTC_RESP_OKAY : `MTC_RESP_SLVERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// write decode; lane 0 gates every field, wide ones included
	logic sel_ctrl, sel_src, sel_lvl, sel_hys, sel_dly, sel_ad, sel_ho, sel_do;
	logic sel_cnt, sel_cmd, sel_unit;
	always_comb begin
		{sel_ctrl, sel_src, sel_lvl, sel_hys, sel_dly, sel_ad} = 6'h00;
		{sel_ho, sel_do, sel_cnt, sel_cmd, sel_unit} = 5'h00;
		wr_ok = 1'b1;
		if (awaddr_q == `MTC_OFS_CTRL) sel_ctrl = 1'b1;
		else if (awaddr_q == `MTC_OFS_SRC) sel_src = 1'b1;
		else if (awaddr_q == `MTC_OFS_LEVEL) sel_lvl = 1'b1;
		else if (awaddr_q == `MTC_OFS_HYST) sel_hys = 1'b1;
		else if (awaddr_q == `MTC_OFS_DELAY) sel_dly = 1'b1;
		else if (awaddr_q == `MTC_OFS_AUTODLY) sel_ad = 1'b1;
		else if (awaddr_q == `MTC_OFS_HOLDOFF) sel_ho = 1'b1;
		else if (awaddr_q == `MTC_OFS_DROPOUT) sel_do = 1'b1;
		else if (awaddr_q == `MTC_OFS_COUNT) sel_cnt = 1'b1;
		else if (awaddr_q == `MTC_OFS_CMD) sel_cmd = 1'b1;
		else if (awaddr_q == `MTC_OFS_UNIT) sel_unit = 1'b1;
		else if (awaddr_q != `MTC_OFS_STATUS && awaddr_q != `MTC_OFS_ERROR) wr_ok = 1'b0;
		if (!wstrb_q[0]) begin
			{sel_ctrl, sel_src, sel_lvl, sel_hys, sel_dly, sel_ad} = 6'h00;
			{sel_ho, sel_do, sel_cnt, sel_cmd, sel_unit} = 5'h00;
		end
	end

	logic cmd_init, cmd_abort, cmd_force, cmd_bus, cmd_errclr, unit_refused;
	assign cmd_init   = wr_go && sel_cmd && wdata_q[`MTC_CMD_INIT];
	assign cmd_abort  = wr_go && sel_cmd && wdata_q[`MTC_CMD_ABORT];
	assign cmd_force  = wr_go && sel_cmd && wdata_q[`MTC_CMD_FORCE];
	assign cmd_bus    = wr_go && sel_cmd && wdata_q[`MTC_CMD_BUSTRG];
	assign cmd_errclr = wr_go && sel_cmd && wdata_q[`MTC_CMD_ERRCLR];
	assign unit_refused = wr_go && sel_unit && i_swr_compute
		&& (wdata_q[3:2] != rat_unit_q);

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_q     <= 5'h00;
			src_q      <= mtc_pkg::MTC_SRC_IMM;
			level_q    <= '0;
			hyst_q     <= '0;
			delay_q    <= '0;
			autodly_q  <= '0;
			holdoff_q  <= '0;
			dropout_q  <= '0;
			count_q    <= `MTC_RST_COUNT;
			pwr_unit_q <= mtc_pkg::MTC_PWR_DBM;
			rat_unit_q <= mtc_pkg::MTC_RAT_DB;
		end else if (wr_go) begin
			if (sel_ctrl) ctrl_q <= wdata_q[4:0];
			if (sel_src && wdata_q[2:0] <= 3'h4) src_q <= mtc_pkg::mtc_src_t'(wdata_q[2:0]);
			if (sel_lvl) level_q <= wdata_q[W-1:0];
			if (sel_hys) hyst_q <= wdata_q[W-1:0];
			if (sel_dly) delay_q <= wdata_q[TW-1:0];
			if (sel_ad) autodly_q <= wdata_q[TW-1:0];
			if (sel_ho) holdoff_q <= wdata_q[TW-1:0];
			if (sel_do) dropout_q <= wdata_q[TW-1:0];
			if (sel_cnt && wdata_q[15:0] != 16'h0000) count_q <= wdata_q[15:0];
			if (sel_unit && wdata_q[1:0] != 2'h3)
				pwr_unit_q <= mtc_pkg::mtc_pwr_unit_t'(wdata_q[1:0]);
			if (sel_unit && !unit_refused && wdata_q[3:2] != 2'h3)
				rat_unit_q <= mtc_pkg::mtc_rat_unit_t'(wdata_q[3:2]);
		end
	end

	// --------------------------------
	// edge detection
	// --------------------------------
	mtc_edge_if #(.W(W)) edge_bus ();
	logic [W-1:0] hyst_abs;
	logic [W+7:0] pct_prod;

	// percent band: level*hyst/128, coarse but cheap
	assign pct_prod  = level_q * hyst_q[7:0];
	assign hyst_abs  = ctrl_q[`MTC_CTRL_HPCT] ? pct_prod[W+6:7] : hyst_q;
	assign edge_bus.level     = level_q;
	assign edge_bus.hyst      = hyst_abs;
	assign edge_bus.slope_neg = ctrl_q[`MTC_CTRL_SLOPE];

	mtc_edge_det #(.W(W)) u_edge (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_power  (i_power),
		.e        (edge_bus)
	);

	// --------------------------------
	// event qualification
	// --------------------------------
	logic ext_edge, int_evt, src_evt, accept, force_ok, imm_go;
	logic [TW-1:0] eff_dly;

	assign ext_edge = ctrl_q[`MTC_CTRL_SLOPE] ? (ext_q && !i_ext_trig)
		: (!ext_q && i_ext_trig);
	assign int_evt  = edge_bus.edge_hit && (drop_cnt_q == '0);
	always_comb begin
		case (src_q)
			mtc_pkg::MTC_SRC_EXT: src_evt = ext_edge;
			mtc_pkg::MTC_SRC_INT: src_evt = int_evt;
			mtc_pkg::MTC_SRC_BUS: src_evt = cmd_bus;
			default:              src_evt = 1'b0;
		endcase
	end
	assign accept   = state_q == mtc_pkg::MTC_WAIT && src_evt && hold_cnt_q == '0;
	assign force_ok = state_q == mtc_pkg::MTC_WAIT && cmd_force;
	assign imm_go   = state_q == mtc_pkg::MTC_WAIT && src_q == mtc_pkg::MTC_SRC_IMM;
	assign eff_dly  = (ctrl_q[`MTC_CTRL_AUTO] && autodly_q > delay_q)
		? autodly_q : delay_q;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ext_q       <= 1'b0;
			was_above_q <= 1'b0;
			drop_cnt_q  <= '0;
		end else begin
			ext_q       <= i_ext_trig;
			was_above_q <= i_power > level_q;
			if (was_above_q && !(i_power > level_q))
				drop_cnt_q <= dropout_q;
			else if (drop_cnt_q != '0)
				drop_cnt_q <= drop_cnt_q - 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			hold_cnt_q <= '0;
		else if (accept)
			hold_cnt_q <= holdoff_q;
		else if (hold_cnt_q != '0)
			hold_cnt_q <= hold_cnt_q - 1'b1;
	end

	// master pulse, one cycle per accepted event
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			o_trig_out <= 1'b0;
		else
			o_trig_out <= ctrl_q[`MTC_CTRL_MASTER] && accept;
	end

	// --------------------------------
	// measurement cycle
	// --------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q    <= mtc_pkg::MTC_IDLE;
			dly_cnt_q  <= '0;
			cyc_left_q <= 16'h0000;
			meas_cnt_q <= 16'h0000;
		end else if (cmd_abort) begin
			state_q <= mtc_pkg::MTC_IDLE;
		end else begin
			case (state_q)
				mtc_pkg::MTC_IDLE: begin
					if (cmd_init || ctrl_q[`MTC_CTRL_CONT]) begin
						state_q    <= mtc_pkg::MTC_INIT;
						cyc_left_q <= count_q;
					end
				end
				mtc_pkg::MTC_INIT: state_q <= mtc_pkg::MTC_WAIT;
				mtc_pkg::MTC_WAIT: begin
					if (force_ok) begin
						dly_cnt_q <= ctrl_q[`MTC_CTRL_AUTO] ? autodly_q : '0;
						state_q   <= mtc_pkg::MTC_DELAY;
					end else if (accept) begin
						dly_cnt_q <= eff_dly;
						state_q   <= mtc_pkg::MTC_DELAY;
					end else if (imm_go) begin
						dly_cnt_q <= '0;
						state_q   <= mtc_pkg::MTC_DELAY;
					end
				end
				mtc_pkg::MTC_DELAY: begin
					if (dly_cnt_q == '0) begin
						state_q    <= mtc_pkg::MTC_MEASURE;
						meas_cnt_q <= 16'(MEAS_CYC - 1);
					end else begin
						dly_cnt_q <= dly_cnt_q - 1'b1;
					end
				end
				mtc_pkg::MTC_MEASURE: begin
					if (meas_cnt_q != 16'h0000) begin
						meas_cnt_q <= meas_cnt_q - 1'b1;
					end else if (cyc_left_q > 16'h0001) begin
						cyc_left_q <= cyc_left_q - 1'b1;
						state_q    <= mtc_pkg::MTC_WAIT;
					end else begin
						state_q <= ctrl_q[`MTC_CTRL_CONT] ? mtc_pkg::MTC_INIT
							: mtc_pkg::MTC_IDLE;
						cyc_left_q <= count_q;
					end
				end
				default: state_q <= mtc_pkg::MTC_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_measuring <= 1'b0;
			o_meas_done <= 1'b0;
		end else begin
			o_measuring <= state_q == mtc_pkg::MTC_MEASURE && !cmd_abort;
			o_meas_done <= state_q == mtc_pkg::MTC_MEASURE && meas_cnt_q == 16'h0000
				&& !cmd_abort;
		end
	end

	// error flags: set wins over clear
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			err_q <= 2'b00;
		else begin
			if (cmd_errclr)
				err_q <= 2'b00;
			if (cmd_force && state_q != mtc_pkg::MTC_WAIT)
				err_q[`MTC_ERR_TRG] <= 1'b1;
			if (unit_refused)
				err_q[`MTC_ERR_UNIT] <= 1'b1;
		end
	end

	// --------------------------------
	// read path
	// --------------------------------
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		if (i_araddr == `MTC_OFS_CTRL) rd_val[4:0] = ctrl_q;
		else if (i_araddr == `MTC_OFS_SRC) rd_val[2:0] = src_q;
		else if (i_araddr == `MTC_OFS_LEVEL) rd_val[W-1:0] = level_q;
		else if (i_araddr == `MTC_OFS_HYST) rd_val[W-1:0] = hyst_q;
		else if (i_araddr == `MTC_OFS_DELAY) rd_val[TW-1:0] = delay_q;
		else if (i_araddr == `MTC_OFS_AUTODLY) rd_val[TW-1:0] = autodly_q;
		else if (i_araddr == `MTC_OFS_HOLDOFF) rd_val[TW-1:0] = holdoff_q;
		else if (i_araddr == `MTC_OFS_DROPOUT) rd_val[TW-1:0] = dropout_q;
		else if (i_araddr == `MTC_OFS_COUNT) rd_val[15:0] = count_q;
		else if (i_araddr == `MTC_OFS_CMD) rd_val = 32'h0000_0000;
		else if (i_araddr == `MTC_OFS_STATUS)
			rd_val[19:0] = {cyc_left_q, edge_bus.armed, state_q};
		else if (i_araddr == `MTC_OFS_UNIT) rd_val[3:0] = {rat_unit_q, pwr_unit_q};
		else if (i_araddr == `MTC_OFS_ERROR)
			rd_val = {err_q[`MTC_ERR_UNIT] ? `MTC_ERR_UNIT_CODE : 16'h0000,
				err_q[`MTC_ERR_TRG] ? `MTC_ERR_TRG_CODE : 16'h0000};
		else rd_ok = 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rvalid <= 1'b0;
			o_rdata  <= 32'h0000_0000;
			o_rresp  <= `MTC_RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_rvalid <= 1'b1;
			o_rdata  <= rd_val;
			o_rresp  <= rd_ok ? `MTC_RESP_OKAY : `MTC_RESP_SLVERR;
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
		end
	end
endmodule

// File: mtc_sig_src.sv
module mtc_sig_src #(
	parameter logic [15:0] STEP = 16'h0040
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	// requested levels
	input  wire logic [15:0] i_target,
	input  wire logic        i_ext_lvl,
	// measured signal and trigger line
	output logic      [15:0] o_power,
	output logic             o_ext_trig
);
	// ----------------------------------------
	// slew-limited, crossings span cycles
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			o_power <= 16'h0000;
		else if (o_power + STEP <= i_target)
			o_power <= o_power + STEP;
		else if (o_power >= i_target + STEP)
			o_power <= o_power - STEP;
		else
			o_power <= i_target;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			o_ext_trig <= 1'b0;
		else
			o_ext_trig <= i_ext_lvl;
	end
endmodule

// File: mtc_trigger_sva.sv
`include "mtc_cfg.svh"

module mtc_trigger_sva #(
	parameter int MEAS_CYC = 20
) (
	// clock and reset
	input wire logic        i_clk,
	input wire logic        i_arst_n,
	// trigger and status
	input wire logic        o_trig_out,
	input wire logic        o_measuring,
	input wire logic        o_meas_done,
	// register bus
	input wire logic        i_awvalid,
	input wire logic        o_awready,
	input wire logic        i_wvalid,
	input wire logic        o_wready,
	input wire logic [1:0]  o_bresp,
	input wire logic        o_bvalid,
	input wire logic        i_bready,
	input wire logic [7:0]  i_araddr,
	input wire logic        i_arvalid,
	input wire logic        o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0]  o_rresp,
	input wire logic        o_rvalid,
	input wire logic        i_rready
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	logic [15:0] mc_q;

	// ----------------------------------------
	// measuring length
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			mc_q <= 16'h0000;
		else
			mc_q <= o_measuring ? mc_q + 16'h0001 : 16'h0000;
	end

	sequence s_rd_take;
		i_arvalid && o_arready;
	endsequence

	sequence s_wr_take;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence

	a_rd_latency: assert property (s_rd_take |=> o_rvalid)
		else $error("read data late");
	a_rd_unmapped: assert property (s_rd_take ##0 (i_araddr > `MTC_OFS_ERROR)
		|=> o_rresp == `MTC_RESP_SLVERR) else $error("unmapped read ok");
	a_cmd_reads0: assert property (s_rd_take ##0 (i_araddr == `MTC_OFS_CMD)
		|=> o_rdata == 32'h0000_0000) else $error("cmd reads nonzero");
	a_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped");
	a_ar_block: assert property (o_rvalid |-> !o_arready)
		else $error("ar taken while busy");
	a_wr_resp: assert property (s_wr_take |-> ##[1:2] o_bvalid)
		else $error("bresp late");
	a_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("bresp dropped");
	a_aw_block: assert property (o_bvalid |-> !o_awready)
		else $error("aw taken while busy");
	a_meas_len: assert property (o_meas_done |-> o_measuring && mc_q == 16'(MEAS_CYC - 1))
		else $error("bad measure length");
	a_trig_meas: assert property (o_trig_out |-> ##[0:60] o_measuring)
		else $error("trigger without measure");
	a_trig_pulse: assert property (o_trig_out |=> !o_trig_out)
		else $error("trigger pulse too long");
endmodule

bind mtc_trigger mtc_trigger_sva #(.MEAS_CYC(MEAS_CYC)) i_mtc_trigger_sva (
	.i_clk, .i_arst_n, .o_trig_out, .o_measuring, .o_meas_done,
	.i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
	.i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready
);

// File: measurement_trigger_control_test.sv
`include "mtc_cfg.svh"
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, s); end end

module measurement_trigger_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MC = 4;
	logic        i_clk = 1'b0;
	logic        i_arst_n = 1'b0;
	logic [15:0] tgt = 16'h0000;
	logic        ext = 1'b0;
	logic        i_swr_compute = 1'b0;
	logic [7:0]  i_awaddr = 8'h00;
	logic [7:0]  i_araddr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic        i_awvalid = 1'b0;
	logic        i_wvalid = 1'b0;
	logic        i_bready = 1'b0;
	logic        i_arvalid = 1'b0;
	logic        i_rready = 1'b0;
	logic [15:0] i_power;
	logic        i_ext_trig, o_trig_out, o_measuring, o_meas_done;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0]  o_bresp, o_rresp, last_b;
	logic [31:0] o_rdata;
	int          n_mismatch = 0;
	int          checked = 0;
	int          cyc = 0;
	int          n_trig = 0;
	int          n_done = 0;

	mtc_sig_src i_mtc_sig_src (.i_clk, .i_arst_n, .i_target(tgt), .i_ext_lvl(ext),
		.o_power(i_power), .o_ext_trig(i_ext_trig));
	mtc_trigger #(.MEAS_CYC(MC)) i_mtc_trigger (.i_clk, .i_arst_n, .i_power, .i_ext_trig,
		.i_swr_compute, .o_trig_out, .o_measuring, .o_meas_done, .i_awaddr, .i_awvalid,
		.o_awready, .i_wdata, .i_wstrb(4'hF), .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
		.i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
		.i_rready);

	always #25 i_clk = ~i_clk;

	// ----------------------------------------
	// counters and hang guard
	// ----------------------------------------
	always @(negedge i_clk) begin
		n_trig += (o_trig_out === 1'b1);
		n_done += (o_meas_done === 1'b1);
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do begin
			@(negedge i_clk);
			ta = i_awvalid && o_awready;
			tw = i_wvalid && o_wready;
			tb = o_bvalid;
			last_b = o_bresp;
			@(posedge i_clk);
			if (ta) i_awvalid <= 1'b0;
			if (tw) i_wvalid <= 1'b0;
		end while (!tb);
		i_bready <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(negedge i_clk);
			ta = i_arvalid && o_arready;
			tr = o_rvalid;
			d = o_rdata;
			r = o_rresp;
			@(posedge i_clk);
			if (ta) i_arvalid <= 1'b0;
		end while (!tr);
		i_rready <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		`CHK(nm, e, d & m)
	endtask

	task automatic wmeas(output int n);
		n = 0;
		@(negedge i_clk);
		while (o_measuring !== 1'b1 && n < 200) begin
			@(negedge i_clk);
			n++;
		end
		@(posedge i_clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		rchk("ctrl rst", `MTC_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
		rchk("src rst", `MTC_OFS_SRC, 32'h7, 32'h3);
		rchk("count rst", `MTC_OFS_COUNT, 32'hFFFF, 32'h1);
		rchk("unit rst", `MTC_OFS_UNIT, 32'hF, 32'h0);
		rchk("cmd read", `MTC_OFS_CMD, 32'hFFFFFFFF, 32'h0);
		rd(8'h40, d, r);
		`CHK("unmapped rd", `MTC_RESP_SLVERR, r)
		wr(8'h44, 32'h1);
		`CHK("unmapped wr", `MTC_RESP_SLVERR, last_b)
		wr(`MTC_OFS_CMD, 32'h4);
		rchk("force idle", `MTC_OFS_ERROR, 32'hFFFF, {16'h0, `MTC_ERR_TRG_CODE});
		wr(`MTC_OFS_CMD, 32'h10);
		rchk("err clr", `MTC_OFS_ERROR, 32'hFFFFFFFF, 32'h0);
	endtask

	task automatic t_unit();
		wr(`MTC_OFS_UNIT, 32'h1);
		rchk("pwr unit", `MTC_OFS_UNIT, 32'hF, 32'h1);
		i_swr_compute <= 1'b1;
		wr(`MTC_OFS_UNIT, 32'h5);
		rchk("ratio kept", `MTC_OFS_UNIT, 32'hC, 32'h0);
		rchk("ratio err", `MTC_OFS_ERROR, 32'hFFFF0000, {`MTC_ERR_UNIT_CODE, 16'h0});
		i_swr_compute <= 1'b0;
		wr(`MTC_OFS_UNIT, 32'h4);
		rchk("ratio set", `MTC_OFS_UNIT, 32'hF, 32'h4);
		wr(`MTC_OFS_CMD, 32'h10);
	endtask

	task automatic t_force(input logic [31:0] ctl, input int lo, input int hi);
		int n;
		wr(`MTC_OFS_SRC, 32'h2);
		wr(`MTC_OFS_DELAY, 32'h1E);
		wr(`MTC_OFS_AUTODLY, 32'hC);
		wr(`MTC_OFS_CTRL, ctl);
		wr(`MTC_OFS_CMD, 32'h1);
		repeat (10) @(posedge i_clk);
		rchk("hold waits", `MTC_OFS_STATUS, 32'h7, 32'h2);
		wr(`MTC_OFS_CMD, 32'h4);
		wmeas(n);
		`CHK("force delay", 1'b1, n >= lo && n <= hi)
		repeat (MC + 6) @(posedge i_clk);
		rchk("single idle", `MTC_OFS_STATUS, 32'h7, 32'h0);
	endtask

	task automatic t_bus();
		int n;
		wr(`MTC_OFS_SRC, 32'h0);
		wr(`MTC_OFS_LEVEL, 32'h100);
		wr(`MTC_OFS_CTRL, 32'h4);
		wr(`MTC_OFS_CMD, 32'h1);
		tgt <= 16'h0200;
		repeat (20) @(posedge i_clk);
		rchk("bus level", `MTC_OFS_STATUS, 32'h7, 32'h2);
		wr(`MTC_OFS_CMD, 32'h8);
		wmeas(n);
		`CHK("bus delay", 1'b1, n >= 24 && n <= 40)
		tgt <= 16'h0000;
		repeat (20) @(posedge i_clk);
	endtask

	task automatic t_int();
		int n, k;
		k = n_trig;
		wr(`MTC_OFS_SRC, 32'h4);
		wr(`MTC_OFS_HYST, 32'h20);
		wr(`MTC_OFS_DELAY, 32'h8);
		wr(`MTC_OFS_CTRL, 32'h8);
		wr(`MTC_OFS_CMD, 32'h1);
		tgt <= 16'h0200;
		wmeas(n);
		`CHK("int delay", 1'b1, n >= 9 && n <= 30)
		`CHK("master pulse", k + 1, n_trig)
		tgt <= 16'h0000;
		repeat (20) @(posedge i_clk);
	endtask

	task automatic t_ext();
		int n;
		wr(`MTC_OFS_SRC, 32'h1);
		wr(`MTC_OFS_DELAY, 32'h0);
		wr(`MTC_OFS_CTRL, 32'h2);
		wr(`MTC_OFS_CMD, 32'h1);
		ext <= 1'b1;
		repeat (10) @(posedge i_clk);
		rchk("ext rise", `MTC_OFS_STATUS, 32'h7, 32'h2);
		ext <= 1'b0;
		wmeas(n);
		`CHK("ext fall", 1'b1, n < 10)
		repeat (MC + 6) @(posedge i_clk);
	endtask

	task automatic t_count_abort();
		int k;
		wr(`MTC_OFS_SRC, 32'h3);
		wr(`MTC_OFS_COUNT, 32'h3);
		wr(`MTC_OFS_CTRL, 32'h0);
		k = n_done;
		wr(`MTC_OFS_CMD, 32'h1);
		repeat (120) @(posedge i_clk);
		`CHK("cycle count", k + 3, n_done)
		rchk("count idle", `MTC_OFS_STATUS, 32'h7, 32'h0);
		wr(`MTC_OFS_COUNT, 32'h1);
		wr(`MTC_OFS_SRC, 32'h2);
		wr(`MTC_OFS_CMD, 32'h1);
		repeat (5) @(posedge i_clk);
		wr(`MTC_OFS_CMD, 32'h2);
		rchk("abort idle", `MTC_OFS_STATUS, 32'h7, 32'h0);
	endtask

	initial begin
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		t_regs();
		t_unit();
		t_force(32'h0, 0, 5);
		t_force(32'h4, 8, 20);
		t_bus();
		t_int();
		t_ext();
		t_count_abort();
		end_of_test();
	end
endmodule
